// ---- logic/bctag_top.sv ----
// breakpoint compare registers and instruction tagging
// assumes an apb master, cpu bus signals synchronous to CLK_SYS
`timescale 1ns/10ps
`default_nettype none

module bctag_top
  import bctag_pkg::*;
#(
  parameter int E_HALF = E_HALF_CYC,
  parameter int E_QTR = E_QTR_CYC,
  parameter int DEPTH = QUEUE_DEPTH
)
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic POR_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [15:0] BUS_DATA,
  input wire logic BUS_VALID,
  input wire logic FETCH_VALID,
  input wire logic [15:0] FETCH_WORD,
  input wire logic QUEUE_ADV,
  input wire logic QUEUE_FLUSH,
  input wire logic INSTR_START,
  input wire logic OPCODE_LOW,
  input wire logic INSTR_BOUNDARY,
  input wire logic BDM_EXIT,
  input wire logic SER_CMD_VALID,
  input wire logic [7:0] SER_CMD_CODE,
  input wire logic SER_TX_OUT,
  input wire logic SER_TX_OE,
  input wire logic LOW_BYTE_STROBE_VALUE,
  input wire logic PORT_E3_OUT,
  input wire logic PORT_E3_OE,
  input wire logic DBG_PIN_IN,
  output logic DBG_PIN_OUT,
  output logic DBG_PIN_OE,
  input wire logic STRB_PIN_IN,
  output logic STRB_PIN_OUT,
  output logic STRB_PIN_OE,
  output logic BUS_E_CLOCK,
  output logic SER_CMD_TAKEN,
  output logic TAG_ACTIVE,
  output logic BDM_ACTIVE,
  output logic BDM_ENTER,
  output logic SWI_REQ
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic byte_hit(input logic [7:0] a, input logic [7:0] b);
    byte_hit = (a == b);
  endfunction : byte_hit

  function automatic logic [31:0] widen8(input logic [7:0] v);
    widen8 = {24'h00_0000, v};
  endfunction : widen8

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] addr_hi_q;
  logic [7:0] addr_lo_q;
  logic [7:0] data_hi_q;
  logic [7:0] data_lo_q;
  logic [7:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic tag_act_q;
  logic bdm_act_q;
  logic brk_pend_q;
  logic bdm_enter_q;
  logic swi_q;
  logic cmd_taken_q;
  logic bus_e_clock_q;
  logic [$clog2(E_HALF+1)-1:0] ecnt_q;
  logic strb_out_q;
  logic strb_oe_q;
  logic dbg_out_q;
  logic dbg_oe_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic wr_fire;
  logic sel_ahi;
  logic sel_alo;
  logic sel_dhi;
  logic sel_dlo;
  logic sel_ctl;
  logic sel_sts;
  logic mapped;
  logic [31:0] rd_mux;
  logic [7:0] status_w;

  assign setup_ph = PSEL && !PENABLE;
  assign wr_fire = PSEL && PENABLE && pready_q && PWRITE;
  assign sel_ahi = (PADDR == OFS_ADDR_HI);
  assign sel_alo = (PADDR == OFS_ADDR_LO);
  assign sel_dhi = (PADDR == OFS_DATA_HI);
  assign sel_dlo = (PADDR == OFS_DATA_LO);
  assign sel_ctl = (PADDR == OFS_CTRL);
  assign sel_sts = (PADDR == OFS_STATUS);
  assign mapped = sel_ahi || sel_alo || sel_dhi || sel_dlo || sel_ctl || sel_sts;

  // ----------------------------------------------------------------
  // queue and head
  // ----------------------------------------------------------------
  logic [17:0] q_head;
  logic q_valid;
  logic [$clog2(DEPTH+1)-1:0] q_count;
  logic [1:0] tag_bits;
  logic [1:0] prog_tag;
  logic head_tagged;

  always_comb
  begin
    status_w = 8'h00;
    status_w[STS_TAG_ACT] = tag_act_q;
    status_w[STS_BDM_ACT] = bdm_act_q;
    status_w[STS_BRK_PEND] = brk_pend_q;
    status_w[STS_HEAD_TAG_LO] = q_valid && q_head[16];
    status_w[STS_HEAD_TAG_HI] = q_valid && q_head[17];
    status_w[7:STS_Q_COUNT] = 3'(q_count);
  end

  assign rd_mux = sel_ahi ? widen8(addr_hi_q) :
                  sel_alo ? widen8(addr_lo_q) :
                  sel_dhi ? widen8(data_hi_q) :
                  sel_dlo ? widen8(data_lo_q) :
                  sel_ctl ? widen8(ctrl_q) :
                  sel_sts ? widen8(status_w) : RD_ZERO;

  // ----------------------------------------------------------------
  // breakpoint compare
  // ----------------------------------------------------------------
  bctag_mode_t mode;
  logic full_mode;
  logic dual_mode;
  logic bp0_hit;
  logic bp1_hit;
  logic data_hit;
  logic dhi_ok;
  logic dlo_ok;
  logic bp_match;
  logic [15:0] cmp_addr;

  assign mode = bctag_mode_t'({ctrl_q[CTL_MODE_HI], ctrl_q[CTL_MODE_LO]});
  assign full_mode = (mode == BCTAG_FULL);
  assign dual_mode = (mode == BCTAG_SWI_DUAL) || (mode == BCTAG_BDM_DUAL);
  // program and immediate breaks alike compare BUS_ADDR, whatever the bus cycle
  assign cmp_addr = BUS_ADDR;

  assign bp0_hit = byte_hit(cmp_addr[15:8], addr_hi_q)
                   && (!ctrl_q[CTL_BP0_LOW] || byte_hit(cmp_addr[7:0], addr_lo_q));
  assign dhi_ok = ctrl_q[CTL_MASK_HI] || byte_hit(BUS_DATA[15:8], data_hi_q);
  assign dlo_ok = ctrl_q[CTL_MASK_LO] || byte_hit(BUS_DATA[7:0], data_lo_q);
  assign data_hit = !ctrl_q[CTL_DATA_EN] || (dhi_ok && dlo_ok);
  // dual mode: data registers form the second address breakpoint
  assign bp1_hit = ctrl_q[CTL_DATA_EN]
                   && byte_hit(cmp_addr[15:8], data_hi_q)
                   && (!ctrl_q[CTL_BP1_LOW] || byte_hit(cmp_addr[7:0], data_lo_q));
  assign bp_match = full_mode ? (bp0_hit && data_hit) :
                    dual_mode ? (bp0_hit || bp1_hit) : 1'b0;

  // ----------------------------------------------------------------
  // e clock generation and strobe window
  // ----------------------------------------------------------------
  logic e_wrap;
  logic e_fall;
  logic strb_win;

  assign e_wrap = (ecnt_q == ($clog2(E_HALF+1))'(E_HALF - 1));
  assign e_fall = bus_e_clock_q && e_wrap;
  // judged on the next count so the registered enable sits on the quarter
  assign strb_win = bus_e_clock_q ? (int'(ecnt_q) + 1 < E_QTR)
                           : (int'(ecnt_q) + 1 >= E_HALF - E_QTR);

  // ----------------------------------------------------------------
  // tag capture
  // ----------------------------------------------------------------
  logic prog_brk;
  logic fetch_cap;
  logic tag_go;
  logic enter_now;

  // pins low mark a byte; each pin feeds only its own bit
  assign tag_bits = tag_act_q ? {!DBG_PIN_IN, !STRB_PIN_IN}
                              : 2'b00;
  assign prog_brk = ctrl_q[CTL_PROG_BRK] || (mode == BCTAG_SWI_DUAL);
  assign prog_tag = (prog_brk && bp_match && !bdm_act_q)
                    ? (BUS_ADDR[0] ? 2'b01 : 2'b10) : 2'b00;
  assign fetch_cap = e_fall && FETCH_VALID;
  assign head_tagged = q_valid && (OPCODE_LOW ? q_head[16] : q_head[17]);
  assign enter_now = !bdm_act_q
                     && ((INSTR_START && head_tagged)
                         || (INSTR_BOUNDARY && brk_pend_q));
  assign tag_go = SER_CMD_VALID && !tag_act_q
                  && (SER_CMD_CODE == CMD_TAG_GO);

  bctag_queue #(
    .DEPTH(DEPTH),
    .WIDTH(18)
  ) u_queue (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .flush(QUEUE_FLUSH),
    .push(fetch_cap),
    .wdata({tag_bits | prog_tag, FETCH_WORD}),
    .pop(QUEUE_ADV),
    .head(q_head),
    .head_valid(q_valid),
    .count(q_count)
  );

  // ----------------------------------------------------------------
  // compare registers, power-on reset only
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge POR_N)
  begin
    if (!POR_N)
    begin
      addr_hi_q <= CMP_RESET;
      addr_lo_q <= CMP_RESET;
      data_hi_q <= CMP_RESET;
      data_lo_q <= CMP_RESET;
    end
    else if (wr_fire)
    begin
      if (sel_ahi)
        addr_hi_q <= PWDATA[7:0];
      if (sel_alo)
        addr_lo_q <= PWDATA[7:0];
      if (sel_dhi)
        data_hi_q <= PWDATA[7:0];
      if (sel_dlo)
        data_lo_q <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // apb response and control register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_q <= CTL_RESET;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RD_ZERO;
    end
    else
    begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph && !mapped;
      prdata_q <= (setup_ph && !PWRITE) ? rd_mux : RD_ZERO;
      if (wr_fire && sel_ctl)
        ctrl_q <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // tagging, debug mode and break state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tag_act_q <= 1'b0;
      bdm_act_q <= 1'b0;
      brk_pend_q <= 1'b0;
      bdm_enter_q <= 1'b0;
      swi_q <= 1'b0;
      cmd_taken_q <= 1'b0;
    end
    else
    begin
      bdm_enter_q <= enter_now;
      // serial commands are dropped while tagging runs
      cmd_taken_q <= SER_CMD_VALID && !tag_act_q;
      if (enter_now)
        tag_act_q <= 1'b0;
      else if (tag_go)
        tag_act_q <= 1'b1;
      if (enter_now)
        bdm_act_q <= 1'b1;
      else if (BDM_EXIT)
        bdm_act_q <= 1'b0;
      // immediate break waits for the next instruction boundary
      if (BUS_VALID && bp_match && !prog_brk && !bdm_act_q
          && (mode != BCTAG_OFF))
        brk_pend_q <= 1'b1;
      else if (enter_now)
        brk_pend_q <= 1'b0;
      swi_q <= (mode == BCTAG_SWI_DUAL) && INSTR_START && head_tagged;
    end
  end

  // ----------------------------------------------------------------
  // e clock divider and pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bus_e_clock_q <= 1'b0;
      ecnt_q <= '0;
      strb_out_q <= 1'b0;
      strb_oe_q <= 1'b0;
      dbg_out_q <= 1'b0;
      dbg_oe_q <= 1'b0;
    end
    else
    begin
      ecnt_q <= e_wrap ? '0 : ecnt_q + 1'b1;
      if (e_wrap)
        bus_e_clock_q <= !bus_e_clock_q;
      // strobe owns the pin inside the window, else port or tag input
      strb_out_q <= strb_win ? LOW_BYTE_STROBE_VALUE : PORT_E3_OUT;
      strb_oe_q <= strb_win || (!tag_act_q && PORT_E3_OE);
      // debug pin turns input-only while it carries the high tag
      dbg_out_q <= SER_TX_OUT;
      dbg_oe_q <= SER_TX_OE && !tag_act_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign BUS_E_CLOCK = bus_e_clock_q;
  assign STRB_PIN_OUT = strb_out_q;
  assign STRB_PIN_OE = strb_oe_q;
  assign DBG_PIN_OUT = dbg_out_q;
  assign DBG_PIN_OE = dbg_oe_q;
  assign SER_CMD_TAKEN = cmd_taken_q;
  assign TAG_ACTIVE = tag_act_q;
  assign BDM_ACTIVE = bdm_act_q;
  assign BDM_ENTER = bdm_enter_q;
  assign SWI_REQ = swi_q;

endmodule : bctag_top

`default_nettype wire

// ---- inc/bctag_pkg.sv ----
// constants for the breakpoint compare and instruction tagging block
// assumes a 32-bit apb master and a 100 MHz system clock
package bctag_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on apb
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ADDR_HI = 8'h00;
  localparam logic [7:0] OFS_ADDR_LO = 8'h04;
  localparam logic [7:0] OFS_DATA_HI = 8'h08;
  localparam logic [7:0] OFS_DATA_LO = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTL_MODE_LO = 0;
  localparam int CTL_MODE_HI = 1;
  localparam int CTL_PROG_BRK = 2;
  localparam int CTL_BP0_LOW = 3;
  localparam int CTL_BP1_LOW = 4;
  localparam int CTL_DATA_EN = 5;
  localparam int CTL_MASK_HI = 6;
  localparam int CTL_MASK_LO = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int STS_TAG_ACT = 0;
  localparam int STS_BDM_ACT = 1;
  localparam int STS_BRK_PEND = 2;
  localparam int STS_HEAD_TAG_LO = 3;
  localparam int STS_HEAD_TAG_HI = 4;
  localparam int STS_Q_COUNT = 5;

  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // serial command code, value arbitrary
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_TAG_GO = 8'h5a;

  // ----------------------------------------------------------------
  // bus e clock timing
  // ----------------------------------------------------------------
  localparam int CLK_SYS_MHZ = 100;
  localparam int E_CLK_MHZ = 12;
  localparam int E_HALF_CYC = CLK_SYS_MHZ / (2 * E_CLK_MHZ);
  localparam int E_QTR_CYC = (E_HALF_CYC / 2 < 1) ? 1 : E_HALF_CYC / 2;

  localparam int QUEUE_DEPTH = 3;

  typedef enum logic [1:0] {
    BCTAG_OFF,
    BCTAG_SWI_DUAL,
    BCTAG_FULL,
    BCTAG_BDM_DUAL
  } bctag_mode_t;

endpackage : bctag_pkg

// ---- logic/bctag_queue.sv ----
// instruction queue mirror: program words with their two tag bits
// assumes push at e falling edge and pop when the cpu advances the queue
`timescale 1ns/10ps
`default_nettype none

module bctag_queue
  import bctag_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int WIDTH = 18
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic head_valid,
  output logic [$clog2(DEPTH+1)-1:0] count
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic [$clog2(DEPTH+1)-1:0] after_pop;
  logic do_pop;

  assign do_pop = pop && (cnt_q != '0);
  assign after_pop = do_pop ? cnt_q - 1'b1 : cnt_q;
  assign head = mem_q[0];
  assign head_valid = (cnt_q != '0);
  assign count = cnt_q;

  // ----------------------------------------------------------------
  // shift storage, tag bits ride along with the bytes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (flush)
      cnt_q <= '0;
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (push && (after_pop == i[$clog2(DEPTH+1)-1:0]))
          mem_q[i] <= wdata;
        else if (do_pop && (i < DEPTH - 1))
          mem_q[i] <= mem_q[i+1];
      end
      if (push && (after_pop < DEPTH[$clog2(DEPTH+1)-1:0]))
        cnt_q <= after_pop + 1'b1;
      else
        cnt_q <= after_pop;
    end
  end

endmodule : bctag_queue

`default_nettype wire

// ---- tb/bctag_top_asserts.sv ----
// concurrent checks on the ports of the breakpoint compare and tagging block
// assumes it is bound to bctag_top and sees nothing but its ports
`timescale 1ns/10ps
`default_nettype none

module bctag_top_asserts
  import bctag_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SER_CMD_VALID,
  input wire logic [7:0] SER_CMD_CODE,
  input wire logic SER_CMD_TAKEN,
  input wire logic TAG_ACTIVE,
  input wire logic BDM_ACTIVE,
  input wire logic BDM_ENTER,
  input wire logic DBG_PIN_OE,
  input wire logic STRB_PIN_OE,
  input wire logic BUS_E_CLOCK
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire unmapped = (PADDR > OFS_STATUS) || (PADDR[1:0] != 2'b00);

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------
  // tagging and debug entry
  // ----------------------------------------------------------------
  a_tag_go: assert property (SER_CMD_VALID && SER_CMD_CODE == CMD_TAG_GO && !TAG_ACTIVE
    && !BDM_ACTIVE |=> TAG_ACTIVE) else $error("tag-go did not start tagging");
  a_cmd_ignored: assert property (TAG_ACTIVE && SER_CMD_VALID |=> !SER_CMD_TAKEN)
    else $error("serial command taken while tagging");
  a_bdm_ends_tag: assert property (BDM_ACTIVE |-> !TAG_ACTIVE)
    else $error("tagging active in debug mode");
  a_tag_drop: assert property ($fell(TAG_ACTIVE) |-> BDM_ACTIVE)
    else $error("tagging ended without debug mode");
  a_bdm_entry: assert property ($rose(BDM_ACTIVE) |-> BDM_ENTER)
    else $error("debug mode without entry pulse");
  a_dbg_release: assert property (TAG_ACTIVE [*2] |-> !DBG_PIN_OE)
    else $error("debug pin driven while tagging");
  a_strb_drive: assert property ($rose(BUS_E_CLOCK) |-> STRB_PIN_OE [*2])
    else $error("strobe not driven around e rise");
  a_strb_release: assert property (TAG_ACTIVE && $past(TAG_ACTIVE) && $fell(BUS_E_CLOCK) |-> !STRB_PIN_OE)
    else $error("strobe pin driven at e fall while tagging");

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  a_err_unmapped: assert property (PREADY && PSEL && unmapped |-> PSLVERR && PRDATA == RD_ZERO)
    else $error("unmapped access not refused");

endmodule : bctag_top_asserts

bind bctag_top bctag_top_asserts u_asserts (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SER_CMD_VALID(SER_CMD_VALID), .SER_CMD_CODE(SER_CMD_CODE), .SER_CMD_TAKEN(SER_CMD_TAKEN),
  .TAG_ACTIVE(TAG_ACTIVE), .BDM_ACTIVE(BDM_ACTIVE), .BDM_ENTER(BDM_ENTER),
  .DBG_PIN_OE(DBG_PIN_OE), .STRB_PIN_OE(STRB_PIN_OE), .BUS_E_CLOCK(BUS_E_CLOCK));

`default_nettype wire

// ---- tb/bctag_tool.sv ----
// development tool model on the two shared tag pins
// assumes both pins have pull-ups and the device owns them while its enable is high
`timescale 1ns/10ps
`default_nettype none

module bctag_tool
(
  input wire logic tag_hi,
  input wire logic tag_lo,
  input wire logic dbg_out,
  input wire logic dbg_oe,
  input wire logic strb_out,
  input wire logic strb_oe,
  output logic dbg_pin,
  output logic strb_pin
);
  // tag is a low level; released pins float to the pull-up
  assign dbg_pin = dbg_oe ? dbg_out : !tag_hi;
  // tool stays off the strobe pin while the device drives it
  assign strb_pin = strb_oe ? strb_out : !tag_lo;
endmodule : bctag_tool

`default_nettype wire

// ---- tb/bctag_top_tb.sv ----
// self-checking bench for bctag_top with a behavioural break model
// assumes the tool model on the tag pins and a 100 MHz system clock
`timescale 1ns/10ps
`default_nettype none

module bctag_top_tb
  import bctag_pkg::*;
;
  logic clk = 0, rst_n = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0, cmd_code = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] bus_addr = 0, bus_data = 0, fetch_word = 0;
  logic [6:0] pl = 0;
  logic [4:0] misc = 0;
  logic fetch_valid = 0, op_low = 0, th = 0, tl = 0, dbg_in, dbg_out, dbg_oe;
  logic strb_in, strb_out, strb_oe, bus_e_clock, tag_act, bdm_act, bdm_enter, swi;
  int miscompares = 0, n_compared = 0;

  always #5 clk = ~clk;

  bctag_top dut (.CLK_SYS(clk), .RST_N(rst_n), .POR_N(por_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BUS_ADDR(bus_addr), .BUS_DATA(bus_data), .BUS_VALID(pl[5]),
    .FETCH_VALID(fetch_valid), .FETCH_WORD(fetch_word), .QUEUE_ADV(pl[0]), .QUEUE_FLUSH(pl[1]),
    .INSTR_START(pl[2]), .OPCODE_LOW(op_low), .INSTR_BOUNDARY(pl[3]), .BDM_EXIT(pl[4]),
    .SER_CMD_VALID(pl[6]), .SER_CMD_CODE(cmd_code), .SER_TX_OUT(misc[0]), .SER_TX_OE(misc[1]),
    .LOW_BYTE_STROBE_VALUE(misc[2]), .PORT_E3_OUT(misc[3]), .PORT_E3_OE(misc[4]), .DBG_PIN_IN(dbg_in),
    .DBG_PIN_OUT(dbg_out), .DBG_PIN_OE(dbg_oe), .STRB_PIN_IN(strb_in), .STRB_PIN_OUT(strb_out),
    .STRB_PIN_OE(strb_oe), .BUS_E_CLOCK(bus_e_clock), .SER_CMD_TAKEN(), .TAG_ACTIVE(tag_act),
    .BDM_ACTIVE(bdm_act), .BDM_ENTER(bdm_enter), .SWI_REQ(swi));

  bctag_tool tool (.tag_hi(th), .tag_lo(tl), .dbg_out(dbg_out), .dbg_oe(dbg_oe),
    .strb_out(strb_out), .strb_oe(strb_oe), .dbg_pin(dbg_in), .strb_pin(strb_in));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t register value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_evt(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t event seen %b expected %b", $time, got, exp);
    end
  endtask : chk_evt

  task automatic hang;
    miscompares++;
    $display("ERROR %0t wait ran out", $time);
    end_of_test;
  endtask : hang

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      hang;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic pulse(input int i);
    @(posedge clk);
    pl[i] <= 1;
    @(posedge clk);
    pl[i] <= 0;
  endtask : pulse

  task automatic cmd(input logic [7:0] c);
    @(posedge clk);
    cmd_code <= c;
    pl[6] <= 1;
    @(posedge clk);
    pl[6] <= 0;
  endtask : cmd

  task automatic wait_e(input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (bus_e_clock !== lvl && n < 50);
    if (n >= 50)
      hang;
  endtask : wait_e

  // one program word per e cycle, tags held low across the falling edge
  task automatic push(input logic h, input logic l);
    @(posedge clk);
    fetch_word <= 16'($urandom);
    fetch_valid <= 1;
    th <= h;
    tl <= l;
    wait_e(1'b1);
    wait_e(1'b0);
    fetch_valid <= 0;
    th <= 0;
    tl <= 0;
  endtask : push

  task automatic watch(output logic s, output logic w);
    s = 0;
    w = 0;
    repeat (4)
    begin
      @(posedge clk);
      if (bdm_enter === 1'b1)
        s = 1;
      if (swi === 1'b1)
        w = 1;
    end
  endtask : watch

  // immediate break decision from control and compare bytes
  function automatic bit brk_hit(input int c, input int rg[4], input int a, input int d);
    bit b0;
    if (c[2] || c[1:0] == 1)
      return 0;
    b0 = (a >> 8) == rg[0] && (!c[3] || (a & 255) == rg[1]);
    if (c[1:0] == 2)
      return b0 && (!c[5] || ((c[6] || (d >> 8) == rg[2]) && (c[7] || (d & 255) == rg[3])));
    return b0 || (c[5] && (a >> 8) == rg[2] && (!c[4] || (a & 255) == rg[3]));
  endfunction : brk_hit

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin : main
    int i, k, a, d, ctl;
    int rg[4];
    logic [31:0] r;
    logic e, s, ex, w;
    k = $urandom(32'h181ed9b1);
    repeat (12) @(posedge clk);
    rst_n <= 1;
    por_n <= 1;
    for (k = 0; k < 5; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0, r, e);
      chk_reg(r, 32'h0);
    end
    for (k = 0; k < 4; k++)
    begin
      rg[k] = $urandom;
      apb(1'b1, 8'(4 * k), 32'(rg[k]), r, e);
    end
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      if (i == 0)
        rst_n <= 0;
      else
        por_n <= 0;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      por_n <= 1;
      for (k = 0; k < 4; k++)
      begin
        apb(1'b0, 8'(4 * k), 32'h0, r, e);
        chk_reg(r, (i == 0) ? 32'(rg[k] & 255) : 32'h0);
      end
    end
    apb(1'b1, 8'h18, 32'($urandom), r, e);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk_reg(r, 32'h0);
    chk_evt(e, 1'b1);
    for (i = 0; i < 40; i++)
    begin
      a = $urandom_range(0, 65535);
      d = $urandom_range(0, 65535);
      ctl = ($urandom & 8'hfc) | (1 + $urandom % 3);
      rg = '{a >> 8, a & 255, ($urandom % 2) ? a >> 8 : d >> 8, ($urandom % 2) ? a & 255 : d & 255};
      k = $urandom % 6;
      if (k < 4)
        rg[k] = rg[k] ^ (1 << ($urandom % 8));
      for (k = 0; k < 4; k++)
        apb(1'b1, 8'(4 * k), 32'(rg[k]), r, e);
      apb(1'b1, OFS_CTRL, 32'(ctl), r, e);
      @(posedge clk);
      bus_addr <= 16'(a);
      bus_data <= 16'(d);
      pulse(5);
      pulse(3);
      watch(s, w);
      chk_evt(s, brk_hit(ctl, rg, a, d));
      chk_evt(w, 1'b0);
      pulse(4);
    end
    bus_addr <= 16'(~a);
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      misc <= 5'($urandom);
      apb(1'b1, OFS_CTRL, 32'(i[0] ^ i[1] ^ i[2]), r, e);
      pulse(1);
      cmd(CMD_TAG_GO);
      cmd(8'h3c);
      chk_evt(tag_act, 1'b1);
      push(1'b0, 1'b0);
      push(i[0], i[1]);
      pulse(0);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk_reg(32'(r[4:3]), 32'({i[0], i[1]}));
      @(posedge clk);
      op_low <= i[2];
      pulse(2);
      watch(s, w);
      ex = i[2] ? i[1] : i[0];
      chk_evt(s, ex);
      chk_evt(w, (i[0] ^ i[1] ^ i[2]) && ex);
      chk_evt(tag_act, !ex);
      pulse(4);
    end
    end_of_test;
  end
endmodule : bctag_top_tb

`default_nettype wire
